// *** hw/pcc_defines.vh ***
// register offsets, field positions, reset values and timing for the pci controller config bank
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// byte addresses on apb
`define PCC_OFF_CFG        12'h170
`define PCC_OFF_IRQ_STAT   12'h180
`define PCC_OFF_IRQ_MASK   12'h184
`define PCC_OFF_FWD_STAT   12'h188
// config register fields
`define PCC_BIT_HARD_RST   11
`define PCC_BIT_SOFT_RST   10
`define PCC_BIT_RD_POLICY  9
`define PCC_BIT_MEM0_EN    8
`define PCC_BIT_MEM1_EN    7
`define PCC_BIT_MEM2_EN    6
`define PCC_BIT_LOAD_SRC   2
// writable bits of the config register
`define PCC_CFG_WMASK      32'h0000_07C4
// reset values
`define PCC_RST_SOFT_RST   1'h0
`define PCC_RST_RD_POLICY  1'h1
`define PCC_RST_MEM0_EN    1'h0
`define PCC_RST_MEM1_EN    1'h0
`define PCC_RST_MEM2_EN    1'h0
`define PCC_RST_LOAD_SRC   1'h0
// interrupt status bits
`define PCC_IRQ_RELOAD_DONE 0
`define PCC_IRQ_BUS_ERROR   1
`define PCC_IRQ_BLOCKED     2
`define PCC_IRQ_W           3
// reload length in clock cycles
`define PCC_RELOAD_CYCLES  8'h04
`endif

// *** hw/pcc_reload.v ***
// configuration space reload sequencer used during a software reset
`timescale 1ns/1ps
`default_nettype none
module pcc_reload #(
	parameter CNT_W = 8
) (
	// clock and reset
	input  wire             sys_clk_in,
	input  wire             rst_in,
	// control
	input  wire             start_in,
	input  wire             src_regs_in,
	input  wire [CNT_W-1:0] len_in,
	// status
	output reg              busy_out,
	output reg              from_eeprom_out,
	output reg              from_regs_out,
	output reg              done_out
);
	reg [CNT_W-1:0] cnt_r;

	// count the reload, steering to eeprom or data registers
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r           <= {CNT_W{1'b0}};
			busy_out        <= 1'b0;
			from_eeprom_out <= 1'b0;
			from_regs_out   <= 1'b0;
			done_out        <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out) begin
				busy_out        <= 1'b1;
				cnt_r           <= len_in;
				from_eeprom_out <= ~src_regs_in;
				from_regs_out   <= src_regs_in;
			end else if (busy_out) begin
				if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
					busy_out        <= 1'b0;
					from_eeprom_out <= 1'b0;
					from_regs_out   <= 1'b0;
					done_out        <= 1'b1;
				end else begin
					cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** hw/pcc_cfg_bank.v ***
// pci controller configuration bank: soft reset, read error policy, space enables
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"
module pcc_cfg_bank #(
	parameter ADDR_W = 12
) (
	// clock and reset
	input  wire              sys_clk_in,
	input  wire              rst_in,
	// strap
	input  wire              pci_boot_mode_in,
	// apb slave
	input  wire              psel_in,
	input  wire              penable_in,
	input  wire              pwrite_in,
	input  wire [ADDR_W-1:0] paddr_in,
	input  wire [31:0]       pwdata_in,
	output reg  [31:0]       prdata_out,
	output reg               pready_out,
	output reg               pslverr_out,
	// eeprom load done status
	input  wire              eeprom_load_done_in,
	// internal bus initiator request
	input  wire              ib_req_in,
	input  wire [1:0]        ib_space_in,
	output reg               ib_fwd_out,
	output reg               ib_blocked_out,
	// initiator read completion from pci side
	input  wire              rd_done_in,
	input  wire              data_parity_error_flag_in,
	input  wire              master_abort_flag_in,
	input  wire              target_abort_flag_in,
	input  wire              target_ready_timeout_flag_in,
	input  wire              retry_timeout_flag_in,
	output reg               ib_rd_ack_out,
	output reg               ib_bus_error_out,
	output reg               ib_data_invalid_out,
	// controller reset and reload
	output reg               ctrl_soft_reset_out,
	output reg               reload_eeprom_out,
	output reg               reload_regs_out,
	// config bits
	output reg               read_error_policy_out,
	output reg               mem_space0_enable_out,
	output reg               mem_space1_enable_out,
	output reg               mem_space2_enable_out,
	output reg               load_config_source_out,
	// interrupt
	output reg               irq_out
);
	reg                     soft_reset_ctl_r;
	reg                     read_error_policy_r;
	reg                     mem_space0_enable_r;
	reg                     mem_space1_enable_r;
	reg                     mem_space2_enable_r;
	reg                     load_config_source_r;
	reg [`PCC_IRQ_W-1:0]    irq_stat_r;
	reg [`PCC_IRQ_W-1:0]    irq_mask_r;
	reg [`PCC_IRQ_W-1:0]    irq_set_nxt;
	reg                     boot_meta_r;
	reg                     boot_sync_r;
	reg                     boot_seen_r;
	reg                     done_meta_r;
	reg                     done_sync_r;
	reg                     soft_reset_ctl_prev_r;
	reg [31:0]              rdata_nxt;
	reg                     err_nxt;
	reg                     space_en_nxt;
	wire                    setup;
	wire                    wr_acc;
	wire                    is_cfg;
	wire                    is_stat;
	wire                    is_mask;
	wire                    is_fwd;
	wire                    known;
	wire                    refused;
	wire                    rd_err;
	wire                    rl_busy;
	wire                    rl_eeprom;
	wire                    rl_regs;
	wire                    rl_done;
	wire                    wr_cfg;
	wire                    wr_stat;
	wire                    wr_mask;
	wire                    soft_reset_ctl_rise;
	wire                    pass_nxt;
	wire                    rd_bus_err;
	wire                    rd_quiet_err;

	// address match on the word offset
	function match;
		input [ADDR_W-1:0] a;
		input [11:0]       off;
		begin
			match = (a[11:2] == off[11:2]);
		end
	endfunction

	// config register image with reserved bits zero
	function [31:0] cfg_image;
		input s;
		input p;
		input m0;
		input m1;
		input m2;
		input l;
		begin
			cfg_image = 32'h0000_0000;
			cfg_image[`PCC_BIT_SOFT_RST]  = s;
			cfg_image[`PCC_BIT_RD_POLICY] = p;
			cfg_image[`PCC_BIT_MEM0_EN]   = m0;
			cfg_image[`PCC_BIT_MEM1_EN]   = m1;
			cfg_image[`PCC_BIT_MEM2_EN]   = m2;
			cfg_image[`PCC_BIT_LOAD_SRC]  = l;
		end
	endfunction

	assign setup   = psel_in && !penable_in;
	assign wr_acc  = setup && pwrite_in && !refused;
	assign is_cfg  = match(paddr_in, `PCC_OFF_CFG);
	assign is_stat = match(paddr_in, `PCC_OFF_IRQ_STAT);
	assign is_mask = match(paddr_in, `PCC_OFF_IRQ_MASK);
	assign is_fwd  = match(paddr_in, `PCC_OFF_FWD_STAT);
	assign known   = is_cfg || is_stat || is_mask || is_fwd;
	// only the config register stays reachable during soft reset
	assign refused = !known || (soft_reset_ctl_r && !is_cfg);
	assign rd_err  = data_parity_error_flag_in || master_abort_flag_in || target_abort_flag_in
		|| target_ready_timeout_flag_in || retry_timeout_flag_in;
	// register writes that the bus actually lets through
	assign wr_cfg  = wr_acc && is_cfg;
	assign wr_stat = wr_acc && is_stat;
	assign wr_mask = wr_acc && is_mask;
	// reload starts once per rising edge of the soft reset bit
	assign soft_reset_ctl_rise = soft_reset_ctl_r && !soft_reset_ctl_prev_r;
	// a request passes only to an enabled space outside soft reset
	assign pass_nxt = space_en_nxt && !soft_reset_ctl_r;
	// error completions split by the read error policy
	assign rd_bus_err   = rd_done_in && rd_err && read_error_policy_r;
	assign rd_quiet_err = rd_done_in && rd_err && !read_error_policy_r;

	// synchronise the boot strap; no reset, so it is settled at release
	always @(posedge sys_clk_in) begin
		boot_meta_r <= pci_boot_mode_in;
		boot_sync_r <= boot_meta_r;
	end

	// synchronise eeprom load done
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_meta_r <= 1'b0;
			done_sync_r <= 1'b0;
		end else begin
			done_meta_r <= eeprom_load_done_in;
			done_sync_r <= done_meta_r;
		end
	end

	// reload sequencer started on the rising edge of soft reset
	pcc_reload #(
		.CNT_W(8)
	) u_reload (
		.sys_clk_in      (sys_clk_in),
		.rst_in          (rst_in),
		.start_in        (soft_reset_ctl_rise),
		.src_regs_in     (load_config_source_r),
		.len_in          (`PCC_RELOAD_CYCLES),
		.busy_out        (rl_busy),
		.from_eeprom_out (rl_eeprom),
		.from_regs_out   (rl_regs),
		.done_out        (rl_done)
	);

	// soft reset and load source, hard reset only; soft reset keeps both
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			soft_reset_ctl_r     <= `PCC_RST_SOFT_RST;
			load_config_source_r <= `PCC_RST_LOAD_SRC;
			soft_reset_ctl_prev_r          <= 1'b0;
		end else begin
			soft_reset_ctl_prev_r <= soft_reset_ctl_r;
			// not self clearing: only a write drops it
			if (wr_cfg) begin
				soft_reset_ctl_r     <= pwdata_in[`PCC_BIT_SOFT_RST];
				load_config_source_r <= pwdata_in[`PCC_BIT_LOAD_SRC];
			end
		end
	end

	// policy and space enables, hard reset only
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			read_error_policy_r <= `PCC_RST_RD_POLICY;
			mem_space0_enable_r <= `PCC_RST_MEM0_EN;
			mem_space1_enable_r <= `PCC_RST_MEM1_EN;
			mem_space2_enable_r <= `PCC_RST_MEM2_EN;
			boot_seen_r         <= 1'b0;
		end else begin
			// strap caught once after release; a write in that cycle still wins
			if (!boot_seen_r) begin
				boot_seen_r         <= 1'b1;
				mem_space2_enable_r <= boot_sync_r;
			end
			if (wr_cfg) begin
				read_error_policy_r <= pwdata_in[`PCC_BIT_RD_POLICY];
				mem_space0_enable_r <= pwdata_in[`PCC_BIT_MEM0_EN];
				mem_space1_enable_r <= pwdata_in[`PCC_BIT_MEM1_EN];
				mem_space2_enable_r <= pwdata_in[`PCC_BIT_MEM2_EN];
			end
		end
	end

	// read mux and error answer
	always @* begin
		rdata_nxt = 32'h0000_0000;
		err_nxt   = refused;
		if (is_cfg)
			rdata_nxt = cfg_image(soft_reset_ctl_r, read_error_policy_r, mem_space0_enable_r,
				mem_space1_enable_r, mem_space2_enable_r, load_config_source_r);
		else if (is_stat && !refused)
			rdata_nxt = {{(32-`PCC_IRQ_W){1'b0}}, irq_stat_r};
		else if (is_mask && !refused)
			rdata_nxt = {{(32-`PCC_IRQ_W){1'b0}}, irq_mask_r};
		else if (is_fwd && !refused)
			rdata_nxt = {28'h000_0000, rl_busy, done_sync_r, ib_blocked_out, ib_fwd_out};
	end

	// apb answer: no wait state, ready in the first access cycle
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out  <= 32'h0000_0000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= setup;
			pslverr_out <= setup && err_nxt;
			if (setup && !pwrite_in)
				prdata_out <= rdata_nxt;
		end
	end

	// space enable lookup
	always @* begin
		case (ib_space_in)
			2'h0:    space_en_nxt = mem_space0_enable_r;
			2'h1:    space_en_nxt = mem_space1_enable_r;
			2'h2:    space_en_nxt = mem_space2_enable_r;
			default: space_en_nxt = 1'b0;
		endcase
	end

	// initiator forwarding: each request answered once, forwarded or blocked
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ib_fwd_out     <= 1'b0;
			ib_blocked_out <= 1'b0;
		end else begin
			ib_fwd_out     <= ib_req_in && pass_nxt;
			ib_blocked_out <= ib_req_in && !pass_nxt;
		end
	end

	// read completion answer to the internal bus
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ib_rd_ack_out       <= 1'b0;
			ib_bus_error_out    <= 1'b0;
			ib_data_invalid_out <= 1'b0;
		end else begin
			ib_rd_ack_out       <= rd_done_in && !rd_bus_err;
			ib_bus_error_out    <= rd_bus_err;
			ib_data_invalid_out <= rd_quiet_err;
		end
	end

	// events for interrupt status
	always @* begin
		irq_set_nxt = {`PCC_IRQ_W{1'b0}};
		irq_set_nxt[`PCC_IRQ_RELOAD_DONE] = rl_done;
		irq_set_nxt[`PCC_IRQ_BUS_ERROR]   = rd_done_in && rd_err;
		irq_set_nxt[`PCC_IRQ_BLOCKED]     = ib_req_in && !pass_nxt;
	end

	// sticky status, write one to clear, set wins; kept over soft reset
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_stat_r <= {`PCC_IRQ_W{1'b0}};
			irq_mask_r <= {`PCC_IRQ_W{1'b0}};
			irq_out    <= 1'b0;
		end else begin
			if (wr_stat)
				irq_stat_r <= (irq_stat_r & ~pwdata_in[`PCC_IRQ_W-1:0]) | irq_set_nxt;
			else
				irq_stat_r <= irq_stat_r | irq_set_nxt;
			if (wr_mask)
				irq_mask_r <= pwdata_in[`PCC_IRQ_W-1:0];
			irq_out <= |(irq_stat_r & irq_mask_r);
		end
	end

	// registered copies of the reset and reload controls
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_soft_reset_out <= 1'b0;
			reload_eeprom_out   <= 1'b0;
			reload_regs_out     <= 1'b0;
		end else begin
			ctrl_soft_reset_out <= soft_reset_ctl_r;
			reload_eeprom_out   <= rl_eeprom;
			reload_regs_out     <= rl_regs;
		end
	end

	// registered copies of the config bits
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			read_error_policy_out  <= `PCC_RST_RD_POLICY;
			mem_space0_enable_out  <= `PCC_RST_MEM0_EN;
			mem_space1_enable_out  <= `PCC_RST_MEM1_EN;
			mem_space2_enable_out  <= `PCC_RST_MEM2_EN;
			load_config_source_out <= `PCC_RST_LOAD_SRC;
		end else begin
			read_error_policy_out  <= read_error_policy_r;
			mem_space0_enable_out  <= mem_space0_enable_r;
			mem_space1_enable_out  <= mem_space1_enable_r;
			mem_space2_enable_out  <= mem_space2_enable_r;
			load_config_source_out <= load_config_source_r;
		end
	end
endmodule
`default_nettype wire

// *** tb/pcc_checker.sv ***
// port assertions for the config bank
`timescale 1ns/1ps
`default_nettype none
module pcc_checker (
	// clock, reset, apb
	input wire logic       sys_clk_in,
	input wire logic       rst_in,
	input wire logic       psel_in,
	input wire logic       penable_in,
	input wire logic       pready_out,
	// initiator side
	input wire logic       ib_req_in,
	input wire logic [1:0] ib_space_in,
	input wire logic       rd_done_in,
	input wire logic       data_parity_error_flag_in,
	input wire logic       master_abort_flag_in,
	input wire logic       target_abort_flag_in,
	input wire logic       target_ready_timeout_flag_in,
	input wire logic       retry_timeout_flag_in,
	input wire logic       ib_fwd_out,
	input wire logic       ib_blocked_out,
	input wire logic       ib_rd_ack_out,
	input wire logic       ib_bus_error_out,
	input wire logic       ib_data_invalid_out,
	// control copies
	input wire logic       ctrl_soft_reset_out,
	input wire logic       reload_eeprom_out,
	input wire logic       reload_regs_out,
	input wire logic       read_error_policy_out,
	input wire logic       mem_space0_enable_out,
	input wire logic       mem_space1_enable_out,
	input wire logic       mem_space2_enable_out,
	input wire logic       load_config_source_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// any initiator read error
	wire logic er = data_parity_error_flag_in | master_abort_flag_in | target_abort_flag_in
		| target_ready_timeout_flag_in | retry_timeout_flag_in;
	a_setup_answer: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready after setup");
	a_req_one_answer: assert property (ib_req_in |=> ib_fwd_out != ib_blocked_out)
		else $error("request not answered once");
	a_space3_blocked: assert property (ib_req_in && ib_space_in == 2'h3 |=> ib_blocked_out)
		else $error("space 3 forwarded");
	a_space0_off: assert property (ib_req_in && ib_space_in == 2'h0 && !mem_space0_enable_out
		##1 !mem_space0_enable_out |-> ib_blocked_out) else $error("disabled space forwarded");
	a_space1_off: assert property (ib_req_in && ib_space_in == 2'h1 && !mem_space1_enable_out
		##1 !mem_space1_enable_out |-> ib_blocked_out) else $error("disabled space 1 forwarded");
	a_space2_off: assert property (ib_req_in && ib_space_in == 2'h2 && !mem_space2_enable_out
		##1 !mem_space2_enable_out |-> ib_blocked_out) else $error("disabled space 2 forwarded");
	a_space0_on: assert property (ib_req_in && ib_space_in == 2'h0 && mem_space0_enable_out
		##1 mem_space0_enable_out && !ctrl_soft_reset_out |-> ib_fwd_out) else $error("enabled space blocked");
	a_reset_blocks: assert property (ib_req_in && ctrl_soft_reset_out ##1 ctrl_soft_reset_out
		|-> ib_blocked_out) else $error("request passed in soft reset");
	a_err_bus: assert property (rd_done_in && er && read_error_policy_out ##1 read_error_policy_out
		|-> ib_bus_error_out && !ib_rd_ack_out) else $error("no bus error");
	a_err_quiet: assert property (rd_done_in && er && !read_error_policy_out ##1 !read_error_policy_out
		|-> ib_rd_ack_out && ib_data_invalid_out && !ib_bus_error_out) else $error("bad quiet error");
	a_reload_eeprom: assert property ($rose(ctrl_soft_reset_out) && !load_config_source_out
		|=> reload_eeprom_out [*4] ##1 !reload_eeprom_out) else $error("eeprom reload wrong");
	a_reload_regs: assert property ($rose(ctrl_soft_reset_out) && load_config_source_out
		|=> reload_regs_out [*4] ##1 !reload_regs_out) else $error("register reload wrong");
endmodule
bind pcc_cfg_bank pcc_checker u_pcc_checker (.*);
`default_nettype wire

// *** tb/pcc_ib_model.sv ***
// internal bus master model: requests and read completions
`timescale 1ns/1ps
`default_nettype none
module pcc_ib_model (
	input  wire logic       sys_clk_in,
	output logic            ib_req_out,
	output logic [1:0]      ib_space_out,
	output logic            rd_done_out,
	output wire logic [4:0] err_out
);
	logic [4:0] ev_r;
	logic [4:0] junk_r = 5'h15;
	initial begin
		ib_req_out = 1'b0;
		ib_space_out = 2'h0;
		rd_done_out = 1'b0;
	end
	// flags only qualify a completion; idle pattern toggles
	always @(posedge sys_clk_in) junk_r <= ~junk_r;
	assign err_out = rd_done_out ? ev_r : junk_r;
	// one request after g idle cycles
	task automatic req(input int g, input logic [1:0] s);
		repeat (g) @(posedge sys_clk_in);
		ib_req_out <= 1'b1;
		ib_space_out <= s;
		@(posedge sys_clk_in);
		ib_req_out <= 1'b0;
		ib_space_out <= ~s;
		@(posedge sys_clk_in);
	endtask
	// one read completion with error flags
	task automatic rd(input int g, input logic [4:0] e);
		repeat (g) @(posedge sys_clk_in);
		rd_done_out <= 1'b1;
		ev_r <= e;
		@(posedge sys_clk_in);
		rd_done_out <= 1'b0;
		@(posedge sys_clk_in);
	endtask
endmodule
`default_nettype wire

// *** tb/test_pci_ctrl_reset_and_space_enable.sv ***
// testbench for the config bank
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"
module test_pci_ctrl_reset_and_space_enable;
	logic        clk = 0, rst = 1, boot, psel = 0, penable = 0, pwrite = 0, eedone = 0, l, p;
	logic        pready, pslverr, fwd, blk, ack, berr, inv, irq, req, rdd;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [33:0] aq[$], ea;
	logic [4:0]  iq[$], ei, errs, e;
	logic [2:0]  en;
	logic [1:0]  sp, s;
	int          fails = 0, n_checks = 0, i, g;
	always #50 clk = ~clk;
	pcc_cfg_bank u_pcc_cfg_bank (.sys_clk_in(clk), .rst_in(rst), .pci_boot_mode_in(boot),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .eeprom_load_done_in(eedone),
		.ib_req_in(req), .ib_space_in(sp), .ib_fwd_out(fwd), .ib_blocked_out(blk), .rd_done_in(rdd),
		.data_parity_error_flag_in(errs[0]), .master_abort_flag_in(errs[1]), .target_abort_flag_in(errs[2]),
		.target_ready_timeout_flag_in(errs[3]), .retry_timeout_flag_in(errs[4]), .ib_rd_ack_out(ack),
		.ib_bus_error_out(berr), .ib_data_invalid_out(inv), .ctrl_soft_reset_out(), .reload_eeprom_out(),
		.reload_regs_out(), .read_error_policy_out(), .mem_space0_enable_out(), .mem_space1_enable_out(),
		.mem_space2_enable_out(), .load_config_source_out(), .irq_out(irq));
	pcc_ib_model u_pcc_ib_model (.sys_clk_in(clk), .ib_req_out(req), .ib_space_out(sp),
		.rd_done_out(rdd), .err_out(errs));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		n_checks++;
		if (y !== x) begin
			$display("[ERR] %s exp %h got %h", n, x, y);
			fails++;
		end
	endtask
	// apb transfer; expectation {check data, error, data}
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
		aq.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {2'b00, d});
	endtask
	task automatic rdx(input logic [11:0] a, input logic [31:0] x, input logic er);
		apb(1'b0, a, 32'h0, {1'b1, er, x});
	endtask
	task automatic ib(input int g, input logic [1:0] s, input logic [4:0] x);
		iq.push_back(x);
		u_pcc_ib_model.req(g, s);
	endtask
	// answer monitor takes the oldest note
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			ea = aq.pop_front();
			chk("pslverr", {31'h0, ea[32]}, {31'h0, pslverr});
			if (ea[33]) chk("prdata", ea[31:0], prdata);
		end
		if (fwd | blk | ack | berr) begin
			ei = iq.pop_front();
			chk("ib", {27'h0, ei}, {27'h0, fwd, blk, ack, berr, inv});
		end
	end
	task automatic report_and_stop;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		fails++;
		report_and_stop;
	end
	initial begin
		void'($urandom(57828));
		boot = 1'($urandom);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rdx(`PCC_OFF_CFG, {22'h0, 1'b1, 2'b00, boot, 6'h00}, 1'b0);
		apb(1'b1, `PCC_OFF_CFG, 32'hFFFF_FBFF, 34'h0);
		rdx(`PCC_OFF_CFG, 32'h0000_03C4, 1'b0);
		for (i = 0; i < 8; i++) begin
			en = 3'($urandom);
			s = i[1:0];
			g = $urandom % 3;
			wr(`PCC_OFF_CFG, {23'h0, en, 6'h00});
			ib(g, s, (s != 2'h3 && en[2 - s]) ? 5'b10000 : 5'b01000);
		end
		for (i = 0; i < 12; i++) begin
			p = i[0];
			e = (i < 2) ? 5'h00 : 5'h01 << (i / 2 - 1);
			wr(`PCC_OFF_CFG, {22'h0, p, 9'h000});
			iq.push_back(e == 5'h00 ? 5'b00100 : (p ? 5'b00010 : 5'b00101));
			u_pcc_ib_model.rd($urandom % 3, e);
		end
		eedone <= 1'b1;
		repeat (3) @(posedge clk);
		rdx(`PCC_OFF_FWD_STAT, 32'h0000_0004, 1'b0);
		// soft reset once from each load source
		g = $urandom % 2;
		for (i = 0; i < 2; i++) begin
			l = i[0] ^ g[0];
			wr(`PCC_OFF_CFG, {21'h0, 2'b11, 6'h00, l, 2'h0});
			rdx(`PCC_OFF_IRQ_STAT, 32'h0, 1'b1);
			ib(0, 2'h0, 5'b01000);
			rdx(`PCC_OFF_CFG, {21'h0, 2'b11, 6'h00, l, 2'h0}, 1'b0);
			repeat (4) @(posedge clk);
			wr(`PCC_OFF_CFG, {22'h0, 1'b1, 6'h00, l, 2'h0});
			rdx(`PCC_OFF_CFG, {22'h0, 1'b1, 6'h00, l, 2'h0}, 1'b0);
		end
		rdx(`PCC_OFF_IRQ_STAT, 32'h0000_0007, 1'b0);
		rdx(12'h1FC, 32'h0, 1'b1);
		wr(`PCC_OFF_IRQ_MASK, 32'h0);
		@(negedge clk) chk("irq", 32'h0, {31'h0, irq});
		wr(`PCC_OFF_IRQ_MASK, 32'h7);
		@(negedge clk) chk("irq", 32'h1, {31'h0, irq});
		wr(`PCC_OFF_IRQ_STAT, 32'h7);
		@(negedge clk) chk("irq", 32'h0, {31'h0, irq});
		repeat (3) @(posedge clk);
		// second reset in mid-run with the strap turned over
		boot <= ~boot;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rdx(`PCC_OFF_CFG, {22'h0, 1'b1, 2'b00, boot, 6'h00}, 1'b0);
		rdx(`PCC_OFF_IRQ_STAT, 32'h0, 1'b0);
		report_and_stop;
	end
endmodule
`default_nettype wire
